// ### hw/lin_slave_header_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "lin_slave_defines.svh"
module lin_slave_header_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire lin_slave_pkg::apb_req_t apb_req,
    output wire lin_slave_pkg::apb_rsp_t apb_rsp,
    // link
    input wire logic receive_line,
    // status
    output wire logic irq,
    output wire logic baud_tick
);
    import lin_slave_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction : maj3

    function automatic logic noisy3(input logic [2:0] v);
        return (|v) & ~(&v);
    endfunction : noisy3

    function automatic logic dev_err(input logic [11:0] m, input logic [11:0] a);
        logic [11:0] d;
        logic [11:0] lim;
        d = (m > a) ? (m - a) : (a - m);
        lim = (a >> `DEV_SHIFT_A) + (a >> `DEV_SHIFT_B);
        return (d > lim) || (m[11:4] == 8'h00);
    endfunction : dev_err

    function automatic logic parity_bad(input logic [7:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return (p0 != id[6]) || (p1 != id[7]);
    endfunction : parity_bad

    ////////////////////////////////////////////////////////////////////////
    lin_state_t state_ff;
    lin_state_t nxt_state;
    logic slave;
    logic rxl;
    logic fall;
    logic halt;
    logic bv;
    logic ev_char;
    logic ev_fe;
    logic ev_brk;
    logic dlv;
    logic [7:0] dlv_data;
    logic nom_wr;
    logic setup_ph;
    logic acc_ph;
    logic mapped;
    logic [7:0] rd_val;
    logic [7:0] wd;
    logic [11:0] div_sel;
    logic [12:0] acc_sum;
    logic [11:0] meas;

    assign apb_rsp.prdata = state_ff.prdata;
    assign apb_rsp.pready = acc_ph;
    assign apb_rsp.pslverr = acc_ph & ~mapped;
    assign baud_tick = state_ff.tick;
    assign irq = (state_ff.rx_irq_enable & (state_ff.header_error_flag
                 | state_ff.rx_full_flag))
                 | (state_ff.parity_irq_enable & state_ff.parity_error_flag)
                 | (state_ff.header_irq_enable & state_ff.header_detect_flag);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        slave = state_ff.lin_enable & state_ff.slave_select;
        setup_ph = apb_req.psel & ~apb_req.penable;
        acc_ph = apb_req.psel & apb_req.penable;
        wd = apb_req.pwdata[7:0];
        nom_wr = 1'b0;
        dlv = 1'b0;
        dlv_data = state_ff.rx_sh;
        ev_char = 1'b0;
        ev_fe = 1'b0;
        ev_brk = 1'b0;
        meas = state_ff.synch_measurement[14:3];
        // baud generator, fractional divider in sixteenths
        div_sel = slave ? state_ff.baud_divider
                        : {state_ff.master_prescaler, 4'h0};
        acc_sum = state_ff.acc + 13'(`OVERSAMPLE);
        nxt_state.tick = 1'b0;
        if (div_sel == 12'h000) begin
            nxt_state.acc = 13'h0000;
        end else if (acc_sum >= {1'b0, div_sel}) begin
            nxt_state.acc = acc_sum - {1'b0, div_sel};
            nxt_state.tick = 1'b1;
        end else begin
            nxt_state.acc = acc_sum;
        end
        // line synchroniser and edge detect
        nxt_state.rx_sync = {state_ff.rx_sync[0], receive_line};
        rxl = state_ff.rx_sync[1];
        nxt_state.rx_prev = rxl;
        fall = state_ff.rx_prev & ~rxl;
        // register bus read mux
        mapped = 1'b1;
        unique case (apb_req.paddr)
            `OFF_STATUS: rd_val = {`STATUS_TX_BITS, state_ff.rx_full_flag, 1'b0,
                                   state_ff.header_error_flag, state_ff.noise_flag,
                                   state_ff.framing_error_flag,
                                   state_ff.parity_error_flag};
            `OFF_DATA: rd_val = state_ff.serial_data_reg;
            `OFF_CTRL1: rd_val = {5'h00, state_ff.parity_check_enable, 1'b0,
                                  state_ff.parity_irq_enable};
            `OFF_CTRL2: rd_val = {2'h0, state_ff.rx_irq_enable, 3'h0,
                                  state_ff.rx_mute, 1'b0};
            `OFF_CTRL3: rd_val = {state_ff.divider_update_method, state_ff.lin_enable,
                                  state_ff.slave_select, state_ff.auto_sync_enable,
                                  state_ff.header_detect_method,
                                  state_ff.header_irq_enable,
                                  state_ff.header_detect_flag,
                                  state_ff.synch_field_state};
            `OFF_MANT: rd_val = state_ff.baud_divider[11:4];
            `OFF_FRAC: rd_val = {4'h0, state_ff.baud_divider[3:0]};
            `OFF_HLEN: rd_val = state_ff.header_length_reg;
            `OFF_PRESC: rd_val = state_ff.master_prescaler;
            default: begin
                rd_val = 8'h00;
                mapped = 1'b0;
            end
        endcase
        if (setup_ph) begin
            nxt_state.prdata = {24'h000000, rd_val};
        end
        // register bus access phase: clears first, hardware sets later
        if (acc_ph && apb_req.pwrite) begin
            unique case (apb_req.paddr)
                `OFF_CTRL1: begin
                    nxt_state.parity_check_enable = wd[`B_PCE];
                    nxt_state.parity_irq_enable = wd[`B_PIE];
                end
                `OFF_CTRL2: begin
                    nxt_state.rx_irq_enable = wd[`B_RIE];
                    if (!(slave && state_ff.rx_full_flag)) begin
                        nxt_state.rx_mute = wd[`B_MUTE];
                    end
                end
                `OFF_CTRL3: begin
                    nxt_state.divider_update_method = wd[`B_DIVIDER_UPDATE_METHOD];
                    nxt_state.lin_enable = wd[`B_LINE];
                    nxt_state.slave_select = wd[`B_SLV];
                    nxt_state.auto_sync_enable = wd[`B_ASE];
                    nxt_state.header_detect_method = wd[`B_HDM];
                    nxt_state.header_irq_enable = wd[`B_HIE];
                    if (!wd[`B_SFS] && state_ff.synch_field_state) begin
                        nxt_state.synch_field_state = 1'b0;
                        nxt_state.hd_st = HD_IDLE;
                        nxt_state.hdr_timing = 1'b0;
                    end
                end
                `OFF_MANT: begin
                    nom_wr = 1'b1;
                    nxt_state.nominal_divider[11:4] = wd;
                    if (!state_ff.divider_update_method) begin
                        nxt_state.baud_divider = {wd, state_ff.nominal_divider[3:0]};
                    end
                end
                `OFF_FRAC: nxt_state.nominal_divider[3:0] = wd[3:0];
                `OFF_PRESC: nxt_state.master_prescaler = wd;
                default: ;
            endcase
        end
        if (acc_ph && !apb_req.pwrite) begin
            unique case (apb_req.paddr)
                `OFF_STATUS: nxt_state.armed = 1'b1;
                `OFF_DATA: begin
                    nxt_state.rx_full_flag = 1'b0;
                    if (state_ff.armed) begin
                        nxt_state.armed = 1'b0;
                        nxt_state.framing_error_flag = 1'b0;
                        nxt_state.parity_error_flag = 1'b0;
                        nxt_state.noise_flag = 1'b0;
                        if (!state_ff.synch_field_state) begin
                            nxt_state.header_error_flag = 1'b0;
                        end
                    end
                end
                `OFF_CTRL3: begin
                    if (state_ff.armed) begin
                        nxt_state.header_detect_flag = 1'b0;
                        nxt_state.armed = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // bit receiver, halted while the synch field is measured
        bv = maj3(state_ff.votes);
        halt = slave & state_ff.auto_sync_enable & (state_ff.hd_st == HD_SYNC);
        if (halt) begin
            nxt_state.rx_st = RX_IDLE;
        end else if (state_ff.rx_st == RX_IDLE) begin
            if (fall) begin
                nxt_state.rx_st = RX_START;
                nxt_state.smp = 4'h0;
                nxt_state.noisy = 1'b0;
                nxt_state.any_one = 1'b0;
            end
        end else if (state_ff.tick) begin
            nxt_state.smp = state_ff.smp + 4'h1;
            if (state_ff.smp >= `VOTE_FIRST && state_ff.smp <= `VOTE_LAST) begin
                nxt_state.votes = {rxl, state_ff.votes[2:1]};
            end
            if (state_ff.smp == `LAST_SAMPLE) begin
                nxt_state.noisy = state_ff.noisy | noisy3(state_ff.votes);
                nxt_state.any_one = state_ff.any_one | bv;
                if (bv) begin
                    nxt_state.low_run = 5'h00;
                end else if (state_ff.low_run != 5'h1F) begin
                    nxt_state.low_run = state_ff.low_run + 5'h01;
                end
                unique case (state_ff.rx_st)
                    RX_START: begin
                        nxt_state.rx_st = bv ? RX_IDLE : RX_DATA;
                        nxt_state.bitc = 4'h0;
                    end
                    RX_DATA: begin
                        if (state_ff.bitc < `DATA_BITS) begin
                            nxt_state.rx_sh = {bv, state_ff.rx_sh[7:1]};
                            nxt_state.bitc = state_ff.bitc + 4'h1;
                        end else if (bv) begin
                            ev_char = 1'b1;
                            nxt_state.rx_st = RX_IDLE;
                        end else if (state_ff.any_one) begin
                            ev_fe = 1'b1;
                            nxt_state.rx_st = RX_IDLE;
                        end else begin
                            nxt_state.rx_st = RX_BRK;
                        end
                    end
                    RX_BRK: begin
                        if (bv) begin
                            nxt_state.rx_st = RX_IDLE;
                            ev_brk = (state_ff.low_run >= `BREAK_BITS);
                        end
                    end
                    RX_IDLE: ;
                endcase
            end
        end
        // header time-out and length
        if (state_ff.hdr_timing && state_ff.tick && state_ff.hdr_ticks != 12'hFFF) begin
            nxt_state.hdr_ticks = state_ff.hdr_ticks + 12'h001;
        end
        if (state_ff.hdr_timing && state_ff.hdr_ticks > 12'(`HDR_MAX_TICKS)) begin
            nxt_state.header_error_flag = 1'b1;
            nxt_state.hdr_timing = 1'b0;
            nxt_state.header_length_reg = state_ff.hdr_ticks[11:4];
            if (state_ff.hd_st == HD_SYNC && state_ff.auto_sync_enable) begin
                nxt_state.hd_st = HD_BLOCK;
            end else begin
                nxt_state.hd_st = HD_IDLE;
                nxt_state.synch_field_state = 1'b0;
            end
        end
        // synch field measurement
        if (halt) begin
            if (state_ff.fall_cnt != 3'h0 || fall) begin
                nxt_state.synch_measurement = state_ff.synch_measurement + 15'h0001;
            end
            if (state_ff.synch_measurement == `MEAS_MAX) begin
                nxt_state.header_error_flag = 1'b1;
                nxt_state.hd_st = HD_BLOCK;
                nxt_state.hdr_timing = 1'b0;
            end else if (fall) begin
                nxt_state.fall_cnt = state_ff.fall_cnt + 3'h1;
                if (state_ff.fall_cnt == `SYNC_LAST_EDGE) begin
                    if (dev_err(meas, state_ff.baud_divider)) begin
                        nxt_state.header_error_flag = 1'b1;
                        nxt_state.hd_st = HD_BLOCK;
                        nxt_state.hdr_timing = 1'b0;
                    end else begin
                        nxt_state.measured_divider = meas;
                        if (!nom_wr) begin
                            nxt_state.baud_divider = meas;
                        end
                        nxt_state.synch_field_state = 1'b0;
                        nxt_state.hd_st = HD_ID;
                    end
                end
            end
        end
        // character events
        if (ev_brk) begin
            if (slave) begin
                nxt_state.hd_st = HD_SYNC;
                nxt_state.synch_field_state = 1'b1;
                nxt_state.hdr_timing = state_ff.header_detect_method
                                       | state_ff.auto_sync_enable;
                nxt_state.hdr_ticks = {3'h0, state_ff.low_run, 4'h0};
                nxt_state.fall_cnt = 3'h0;
                nxt_state.synch_measurement = 15'h0000;
                if (!state_ff.header_detect_method) begin
                    nxt_state.header_detect_flag = 1'b1;
                    nxt_state.rx_mute = 1'b0;
                    dlv = 1'b1;
                    dlv_data = 8'h00;
                end
            end else if (!state_ff.rx_mute) begin
                nxt_state.framing_error_flag = 1'b1;
            end
        end
        if (ev_fe) begin
            if (slave && state_ff.hd_st == HD_SYNC) begin
                nxt_state.header_error_flag = 1'b1;
                nxt_state.hd_st = HD_IDLE;
                nxt_state.synch_field_state = 1'b0;
                nxt_state.hdr_timing = 1'b0;
            end else if (slave && state_ff.hd_st == HD_ID) begin
                nxt_state.hd_st = HD_IDLE;
                nxt_state.hdr_timing = 1'b0;
            end
            if (!state_ff.rx_mute) begin
                nxt_state.framing_error_flag = 1'b1;
            end
        end
        if (ev_char) begin
            if (slave && state_ff.hd_st == HD_SYNC) begin
                nxt_state.synch_field_state = 1'b0;
                if (state_ff.rx_sh != `SYNCH_BYTE) begin
                    nxt_state.header_error_flag = 1'b1;
                    nxt_state.hd_st = HD_IDLE;
                    nxt_state.hdr_timing = 1'b0;
                end else begin
                    nxt_state.hd_st = HD_ID;
                    dlv = ~state_ff.header_detect_method & ~state_ff.rx_mute;
                end
            end else if (slave && state_ff.hd_st == HD_ID) begin
                nxt_state.hd_st = HD_IDLE;
                nxt_state.hdr_timing = 1'b0;
                nxt_state.header_length_reg = state_ff.hdr_ticks[11:4];
                if (state_ff.parity_check_enable && parity_bad(state_ff.rx_sh)) begin
                    nxt_state.parity_error_flag = 1'b1;
                end
                if (state_ff.header_detect_method) begin
                    nxt_state.header_detect_flag = 1'b1;
                    nxt_state.rx_mute = 1'b0;
                    dlv = 1'b1;
                end else begin
                    dlv = ~state_ff.rx_mute;
                end
            end else if (!(slave && state_ff.hd_st == HD_BLOCK)) begin
                dlv = ~state_ff.rx_mute;
            end
        end
        // delivery into the data register
        if (dlv) begin
            if (state_ff.rx_full_flag) begin
                nxt_state.header_error_flag = 1'b1;
            end else begin
                nxt_state.serial_data_reg = dlv_data;
                nxt_state.rx_full_flag = 1'b1;
                if (!slave && state_ff.noisy) begin
                    nxt_state.noise_flag = 1'b1;
                end
                if (slave && state_ff.divider_update_method && !halt) begin
                    nxt_state.baud_divider = state_ff.nominal_divider;
                    nxt_state.divider_update_method = 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= lin_state_t'(0);
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule : lin_slave_header_sync
`default_nettype wire

// ### hw/lin_slave_defines.svh
`ifndef LIN_SLAVE_DEFINES_SVH
`define LIN_SLAVE_DEFINES_SVH
// register offsets, byte addresses
`define OFF_STATUS 8'h00
`define OFF_DATA 8'h04
`define OFF_CTRL1 8'h08
`define OFF_CTRL2 8'h0C
`define OFF_CTRL3 8'h10
`define OFF_MANT 8'h14
`define OFF_FRAC 8'h18
`define OFF_HLEN 8'h1C
`define OFF_PRESC 8'h20
// status reset and fixed transmitter bits
`define STATUS_RST 8'hC0
`define STATUS_TX_BITS 2'h3
// control bit positions
`define B_PIE 0
`define B_MUTE 1
`define B_PCE 2
`define B_RIE 5
`define B_SFS 0
`define B_HDF 1
`define B_HIE 2
`define B_HDM 3
`define B_ASE 4
`define B_SLV 5
`define B_LINE 6
`define B_DIVIDER_UPDATE_METHOD 7
// timing
`define OVERSAMPLE 16
`define LAST_SAMPLE 4'hF
`define VOTE_FIRST 4'h7
`define VOTE_LAST 4'h9
`define DATA_BITS 4'h8
`define BREAK_BITS 5'h0B
`define HDR_MAX_BITS 57
`define HDR_MAX_TICKS (`HDR_MAX_BITS * `OVERSAMPLE)
`define SYNC_EDGES 5
`define SYNC_LAST_EDGE 3'(`SYNC_EDGES - 1)
`define MEAS_SHIFT 3
`define DEV_SHIFT_A 3
`define DEV_SHIFT_B 5
`define SYNCH_BYTE 8'h55
`define MEAS_MAX 15'h7FFF
`endif

// ### hw/lin_slave_pkg.sv
package lin_slave_pkg;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_BRK = 2'b11
    } rx_state_t;
    typedef enum logic [1:0] {
        HD_IDLE = 2'b00,
        HD_SYNC = 2'b01,
        HD_ID = 2'b10,
        HD_BLOCK = 2'b11
    } hdr_state_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
    typedef struct packed {
        logic [1:0] rx_sync;
        logic rx_prev;
        rx_state_t rx_st;
        logic [3:0] smp;
        logic [3:0] bitc;
        logic [2:0] votes;
        logic [7:0] rx_sh;
        logic noisy;
        logic any_one;
        logic [4:0] low_run;
        hdr_state_t hd_st;
        logic hdr_timing;
        logic [11:0] hdr_ticks;
        logic [7:0] header_length_reg;
        logic [2:0] fall_cnt;
        logic [14:0] synch_measurement;
        logic [11:0] nominal_divider;
        logic [11:0] measured_divider;
        logic [11:0] baud_divider;
        logic [12:0] acc;
        logic tick;
        logic parity_check_enable;
        logic parity_irq_enable;
        logic rx_irq_enable;
        logic rx_mute;
        logic divider_update_method;
        logic lin_enable;
        logic slave_select;
        logic auto_sync_enable;
        logic header_detect_method;
        logic header_irq_enable;
        logic header_detect_flag;
        logic synch_field_state;
        logic [7:0] master_prescaler;
        logic rx_full_flag;
        logic header_error_flag;
        logic noise_flag;
        logic framing_error_flag;
        logic parity_error_flag;
        logic [7:0] serial_data_reg;
        logic armed;
        logic [31:0] prdata;
    } lin_state_t;
endpackage : lin_slave_pkg

// ### tb/lin_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module lin_bus_model #(parameter int BIT = 261) (
    // clock
    input wire logic pclk,
    // link, pulled up: released line is recessive
    output var logic line
);
    initial line = 1'b1;
    task automatic hold(input logic v, input int bits);
        line <= v;
        repeat (bits * BIT) @(posedge pclk);
    endtask : hold
    // 8N1, lsb first, stop plus idle gap
    task automatic send_byte(input logic [7:0] b, input int gap);
        hold(1'b0, 1);
        for (int i = 0; i < 8; i++) hold(b[i], 1);
        hold(1'b1, 1 + gap);
    endtask : send_byte
    task automatic send_break();
        hold(1'b0, 13);
        hold(1'b1, 2);
    endtask : send_break
endmodule : lin_bus_model
`default_nettype wire

// ### tb/lin_slave_header_sync_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "lin_slave_defines.svh"
module lin_slave_header_sync_sva (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus, link, outputs
    input wire lin_slave_pkg::apb_req_t apb_req,
    input wire lin_slave_pkg::apb_rsp_t apb_rsp,
    input wire logic receive_line,
    input wire logic irq,
    input wire logic baud_tick
);
    import lin_slave_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic rd;
    assign acc = apb_req.psel && apb_req.penable;
    assign rd = acc && !apb_req.pwrite;
    property p_rdy; apb_rsp.pready == acc; endproperty
    a_rdy: assert property (p_rdy) else $error("pready wrong");
    property p_err; apb_rsp.pslverr |-> apb_rsp.pready; endproperty
    a_err: assert property (p_err) else $error("pslverr outside access");
    property p_upper; rd |-> apb_rsp.prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_status;
        rd && apb_req.paddr == `OFF_STATUS |-> apb_rsp.prdata[7:6] == 2'h3;
    endproperty
    a_status: assert property (p_status) else $error("status top bits");
    property p_frac; rd && apb_req.paddr == `OFF_FRAC |-> apb_rsp.prdata[7:4] == 4'h0; endproperty
    a_frac: assert property (p_frac) else $error("fraction upper bits");
    property p_hold; acc |=> $stable(apb_rsp.prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap;
        acc && apb_req.paddr > `OFF_PRESC |-> apb_rsp.pslverr && apb_rsp.prdata == 0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_map;
        acc && apb_req.paddr <= `OFF_PRESC && apb_req.paddr[1:0] == 2'h0 |-> !apb_rsp.pslverr;
    endproperty
    a_map: assert property (p_map) else $error("mapped refused");
    c_stat: cover property (rd && apb_req.paddr == `OFF_STATUS && apb_rsp.prdata[3]);
    c_unmap: cover property (acc && apb_rsp.pslverr);
    c_irq: cover property (irq || baud_tick);
endmodule : lin_slave_header_sync_sva
bind lin_slave_header_sync lin_slave_header_sync_sva i_sva (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .receive_line(receive_line), .irq(irq),
    .baud_tick(baud_tick));
`default_nettype wire

// ### tb/lin_slave_header_sync_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "lin_slave_defines.svh"
module lin_slave_header_sync_test;
    import lin_slave_pkg::*;
    logic pclk, presetn, irq, baud_tick, rx_line, err;
    apb_req_t req;
    apb_rsp_t rsp;
    logic [31:0] rd;
    int err_count, checked, ticks;
    lin_slave_header_sync i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .receive_line(rx_line), .irq(irq), .baud_tick(baud_tick));
    lin_bus_model i_bus (.pclk(pclk), .line(rx_line));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        req <= '{1'b1, 1'b0, wr, a, {24'h0, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) @(posedge pclk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge pclk);
    endtask : xfer
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 8'h00);
        check(what, rd, exp);
    endtask : rdchk
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (80000) @(posedge pclk);
        err_count++;
        wrap_up();
    end
    initial begin
        req = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("status", `OFF_STATUS, 32'hC0);
        xfer(1'b1, `OFF_FRAC, 8'h02);
        xfer(1'b1, `OFF_MANT, 8'h10);
        rdchk("mant", `OFF_MANT, 32'h10);
        rdchk("frac", `OFF_FRAC, 32'h02);
        rdchk("unmapped", 8'h40, 32'h0);
        check("slverr", err, 1'b1);
        $display("test registers done");
        // slave, auto sync, identifier wake from mute
        xfer(1'b1, `OFF_CTRL3, 8'h78);
        ticks = 0;
        repeat (258) begin
            @(negedge pclk);
            ticks += int'(baud_tick);
        end
        @(posedge pclk);
        check("ticks", ticks, 16);
        xfer(1'b1, `OFF_CTRL2, 8'h02);
        i_bus.send_break();
        i_bus.send_byte(8'h55, 0);
        i_bus.send_byte(8'hC1, 0);
        repeat (20) @(posedge pclk);
        rdchk("status hdr", `OFF_STATUS, 32'hE0);
        rdchk("data id", `OFF_DATA, 32'hC1);
        xfer(1'b0, `OFF_HLEN, 8'h00);
        check("hlen set", rd != 0, 1'b1);
        xfer(1'b0, `OFF_MANT, 8'h00);
        check("synced mant", rd[7:0], 8'h10);
        rdchk("synced frac", `OFF_FRAC, 32'h05);
        rdchk("woke", `OFF_CTRL2, 32'h00);
        rdchk("status clr", `OFF_STATUS, 32'hC0);
        rdchk("ctrl3", `OFF_CTRL3, 32'h7A);
        $display("test header done");
        // header time-out in mute keeps mute
        xfer(1'b1, `OFF_CTRL2, 8'h22);
        i_bus.send_break();
        i_bus.send_byte(8'h55, 40);
        i_bus.send_byte(8'hC1, 0);
        repeat (20) @(posedge pclk);
        rdchk("status tmo", `OFF_STATUS, 32'hC8);
        check("irq tmo", irq, 1'b1);
        rdchk("still mute", `OFF_CTRL2, 32'h22);
        xfer(1'b0, `OFF_DATA, 8'h00);
        rdchk("hdr err clr", `OFF_STATUS, 32'hC0);
        check("irq clr", irq, 1'b0);
        $display("test timeout done");
        // synch far off the local divider blocks until synch state is aborted
        xfer(1'b1, `OFF_MANT, 8'h0C);
        i_bus.send_break();
        i_bus.send_byte(8'h55, 2);
        rdchk("status blk", `OFF_STATUS, 32'hC8);
        xfer(1'b0, `OFF_DATA, 8'h00);
        rdchk("blk held", `OFF_STATUS, 32'hC8);
        rdchk("blk sfs", `OFF_CTRL3, 32'h79);
        xfer(1'b1, `OFF_CTRL3, 8'h78);
        rdchk("blk open", `OFF_STATUS, 32'hC8);
        xfer(1'b0, `OFF_DATA, 8'h00);
        rdchk("blk clr", `OFF_STATUS, 32'hC0);
        $display("test block done");
        wrap_up();
    end
endmodule : lin_slave_header_sync_test
`default_nettype wire
